// ==== les_pkg.sv ====
package les_pkg;

   // Register map of the block (word aligned byte addresses)
   localparam int unsigned LES_ADDR_W     = 8;
   localparam logic [7:0]  LES_OFF_CTRL   = 8'h00;
   localparam logic [7:0]  LES_OFF_STAT   = 8'h04;
   localparam logic [7:0]  LES_OFF_CLR    = 8'h08;
   localparam logic [7:0]  LES_OFF_EN     = 8'h0c;
   localparam logic [7:0]  LES_OFF_STATE  = 8'h10;

   // Link event control fields
   localparam int unsigned LES_NUM_EVT    = 3;
   localparam int unsigned LES_FLD_W      = 3;
   localparam int unsigned LES_PBDN_LSB   = 9;
   localparam int unsigned LES_PCUP_LSB   = 12;
   localparam int unsigned LES_PCDN_LSB   = 15;
   localparam logic [31:0] LES_CTRL_RST   = 32'h0000_0000;
   localparam logic [31:0] LES_CTRL_MASK  = 32'h0003_fe00;

   // Action codes
   localparam logic [2:0]  LES_ACT_MASK   = 3'h0;
   localparam logic [2:0]  LES_ACT_MSI    = 3'h1;
   localparam logic [2:0]  LES_ACT_INTA   = 3'h2;
   localparam logic [2:0]  LES_ACT_INTB   = 3'h3;
   localparam logic [2:0]  LES_ACT_INTC   = 3'h4;
   localparam logic [2:0]  LES_ACT_INTD   = 3'h5;

   // Block interrupt status bits
   localparam int unsigned LES_IRQ_W      = 3;
   localparam int unsigned LES_IRQ_SENT   = 0;
   localparam int unsigned LES_IRQ_RSVD   = 1;
   localparam int unsigned LES_IRQ_DROP   = 2;
   localparam logic [2:0]  LES_IRQ_RST    = 3'h0;

   typedef enum logic [1:0] {
      LES_MSG_MSI    = 2'h0,
      LES_MSG_ASSERT = 2'h1,
      LES_MSG_NEGATE = 2'h2
   } les_msg_kind_t;

   typedef struct packed {
      les_msg_kind_t kind;
      logic [1:0]    line;
      logic [1:0]    src;
   } les_msg_t;

   typedef struct packed {
      logic       msi;
      logic       intx;
      logic       rsvd;
      logic [1:0] line;
   } les_act_t;

   typedef enum logic [1:0] {
      LES_S_IDLE     = 2'b00,
      LES_S_SEND_SET = 2'b01,
      LES_S_ACTIVE   = 2'b11,
      LES_S_SEND_CLR = 2'b10
   } les_chan_st_t;

   function automatic les_act_t les_decode(input logic [2:0] code);
      les_act_t a;
      a = '0;
      case (code)
         LES_ACT_MASK: a = '0;
         LES_ACT_MSI:  a.msi = 1'b1;
         LES_ACT_INTA, LES_ACT_INTB, LES_ACT_INTC, LES_ACT_INTD: begin
            a.intx = 1'b1;
            a.line = 2'(code - LES_ACT_INTA);
         end
         default:      a.rsvd = 1'b1;
      endcase
      return a;
   endfunction

   function automatic int unsigned les_field_lsb(input int unsigned idx);
      case (idx)
         0:       return LES_PBDN_LSB;
         1:       return LES_PCUP_LSB;
         default: return LES_PCDN_LSB;
      endcase
   endfunction

endpackage

// ==== les_evt_chan.sv ====
module les_evt_chan
   import les_pkg::*;
#(
   parameter logic [1:0] SRC = 2'h0
) (
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst,
   // Event and configuration
   input  wire logic       evt_status,
   input  wire logic [2:0] action,
   input  wire logic       msi_en,
   input  wire logic       legacy_irq_disable,
   // Message request
   input  wire logic       grant,
   output logic            req,
   output les_msg_t        msg,
   // Reporting
   output logic            rsvd_seen,
   output logic            dropped,
   output logic            asserted
);

   les_chan_st_t  st_q, st_d;
   les_msg_kind_t kind_q, kind_d;
   logic [1:0]    line_q, line_d;
   logic          asr_q, asr_d;
   logic          gate_ok;
   les_act_t      act;

   assign gate_ok  = (kind_q == LES_MSG_MSI) ? msi_en : !legacy_irq_disable;
   assign req      = ((st_q == LES_S_SEND_SET) || (st_q == LES_S_SEND_CLR))
                     && gate_ok;
   assign msg      = '{kind: kind_q, line: line_q, src: SRC};
   assign asserted = asr_q;

   always_comb begin
      st_d      = st_q;
      kind_d    = kind_q;
      line_d    = line_q;
      asr_d     = asr_q;
      rsvd_seen = 1'b0;
      dropped   = 1'b0;
      act       = les_decode(action);
      case (st_q)
         LES_S_IDLE: begin
            if (evt_status) begin
               if (act.msi && msi_en) begin
                  kind_d = LES_MSG_MSI;
                  line_d = 2'h0;
                  st_d   = LES_S_SEND_SET;
               end else if (act.intx && !legacy_irq_disable) begin
                  kind_d = LES_MSG_ASSERT;
                  line_d = act.line;
                  st_d   = LES_S_SEND_SET;
               end else begin
                  st_d      = LES_S_ACTIVE;
                  rsvd_seen = act.rsvd;
                  dropped   = act.msi | act.intx;
               end
            end
         end
         LES_S_SEND_SET: begin
            if (!gate_ok) begin
               st_d    = LES_S_ACTIVE;
               dropped = 1'b1;
            end else if (grant) begin
               st_d  = LES_S_ACTIVE;
               asr_d = (kind_q == LES_MSG_ASSERT);
            end
         end
         LES_S_ACTIVE: begin
            if (!evt_status) begin
               if (asr_q && !legacy_irq_disable) begin
                  kind_d = LES_MSG_NEGATE;
                  st_d   = LES_S_SEND_CLR;
               end else begin
                  st_d    = LES_S_IDLE;
                  dropped = asr_q;
                  asr_d   = 1'b0;
               end
            end
         end
         LES_S_SEND_CLR: begin
            if (legacy_irq_disable) begin
               st_d    = LES_S_IDLE;
               asr_d   = 1'b0;
               dropped = 1'b1;
            end else if (grant) begin
               st_d  = LES_S_IDLE;
               asr_d = 1'b0;
            end
         end
         default: st_d = LES_S_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st_q   <= LES_S_IDLE;
         kind_q <= LES_MSG_MSI;
         line_q <= 2'h0;
         asr_q  <= 1'b0;
      end else begin
         st_q   <= st_d;
         kind_q <= kind_d;
         line_q <= line_d;
         asr_q  <= asr_d;
      end
   end

   msi_gate_a: assert property (@(posedge clk_sys) disable iff (rst)
      req && msg.kind == LES_MSG_MSI |-> msi_en)
      else $error("MSI requested while capability disabled");

   intx_gate_a: assert property (@(posedge clk_sys) disable iff (rst)
      req && msg.kind != LES_MSG_MSI |-> !legacy_irq_disable)
      else $error("INTx requested while disabled");

   mask_quiet_a: assert property (@(posedge clk_sys) disable iff (rst)
      st_q == LES_S_IDLE && evt_status && action == LES_ACT_MASK
      |=> st_q == LES_S_ACTIVE && !req ##1 !req)
      else $error("Masked event produced a request");

   msi_select_a: assert property (@(posedge clk_sys) disable iff (rst)
      st_q == LES_S_IDLE && evt_status && action == LES_ACT_MSI && msi_en
      |=> (req || !msi_en) && msg.kind == LES_MSG_MSI
          && msg.line == 2'h0)
      else $error("MSI action did not request an MSI");

   inta_line_a: assert property (@(posedge clk_sys) disable iff (rst)
      st_q == LES_S_IDLE && evt_status && action == LES_ACT_INTA
      && !legacy_irq_disable
      |=> msg.kind == LES_MSG_ASSERT && msg.line == 2'h0)
      else $error("INTA action used wrong line");

   intb_line_a: assert property (@(posedge clk_sys) disable iff (rst)
      st_q == LES_S_IDLE && evt_status && action == LES_ACT_INTB
      && !legacy_irq_disable
      |=> msg.kind == LES_MSG_ASSERT && msg.line == 2'h1)
      else $error("INTB action used wrong line");

   intcd_line_a: assert property (@(posedge clk_sys) disable iff (rst)
      st_q == LES_S_IDLE && evt_status && !legacy_irq_disable
      && (action == LES_ACT_INTC || action == LES_ACT_INTD)
      |=> msg.line == ((action == LES_ACT_INTC) ? 2'h2 : 2'h3)
          && msg.kind == LES_MSG_ASSERT)
      else $error("INTC or INTD action used wrong line");

   negate_follow_a: assert property (@(posedge clk_sys)
      disable iff (rst)
      st_q == LES_S_ACTIVE && asr_q && !evt_status && !legacy_irq_disable
      |=> (req || legacy_irq_disable) && msg.kind == LES_MSG_NEGATE
          && msg.line == $past(line_q))
      else $error("Status clear did not request a negation");

endmodule

// ==== les_irq_select.sv ====
// The implementer's own choices: the plain strobed port and the placing of the registers.
module les_irq_select
   import les_pkg::*;
(
   // Clock and reset
   input  wire logic                  clk_sys,
   input  wire logic                  rst,
   // Register port
   input  wire logic [LES_ADDR_W-1:0] reg_addr,
   input  wire logic [31:0]           reg_wdata,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   output logic      [31:0]           reg_rdata,
   // Event status and gating from the configuration space
   input  wire logic [2:0]            event_status_register,
   input  wire logic                  msg_irq_capability_en,
   input  wire logic                  legacy_irq_disable,
   // Outgoing interrupt message
   output logic                       msg_valid,
   input  wire logic                  msg_ready,
   output les_msg_t                   msg,
   // Block interrupt
   output logic                       irq
);

   logic [31:0]          ctrl_q, ctrl_d;
   logic [LES_IRQ_W-1:0] stat_q, stat_d;
   logic [LES_IRQ_W-1:0] en_q, en_d;
   logic [31:0]          rdata_q, rdata_d;
   logic                 mvalid_q, mvalid_d;
   les_msg_t             msg_q, msg_d;

   logic [2:0]           act     [LES_NUM_EVT];
   logic [LES_NUM_EVT-1:0] req, grant, rsvd_seen, dropped, asserted;
   les_msg_t             cmsg    [LES_NUM_EVT];
   logic                 slot_free;
   logic                 accepted;
   logic [LES_IRQ_W-1:0] evt_set;

   function automatic logic hit(input logic [LES_ADDR_W-1:0] a,
                                input logic [7:0]            off);
      return a == off;
   endfunction

   // Event channels, one per link event field
   genvar gi;
   generate
      for (gi = 0; gi < LES_NUM_EVT; gi++) begin : g_chan
         localparam int unsigned LSB = les_field_lsb(gi);
         assign act[gi] = ctrl_q[LSB +: LES_FLD_W];

         les_evt_chan #(
            .SRC (2'(gi))
         ) u_chan (
            .clk_sys            (clk_sys),
            .rst                (rst),
            .evt_status         (event_status_register[gi]),
            .action             (act[gi]),
            .msi_en             (msg_irq_capability_en),
            .legacy_irq_disable (legacy_irq_disable),
            .grant              (grant[gi]),
            .req                (req[gi]),
            .msg                (cmsg[gi]),
            .rsvd_seen          (rsvd_seen[gi]),
            .dropped            (dropped[gi]),
            .asserted           (asserted[gi])
         );

         field_map_a: assert property (@(posedge clk_sys)
            disable iff (rst)
            reg_wr && hit(reg_addr, LES_OFF_CTRL)
            |=> act[gi] == $past(reg_wdata[LSB +: LES_FLD_W]))
            else $error("Action field not taken from its control bits");
      end
   endgenerate

   // Output slot and fixed priority arbitration, lowest event first
   assign accepted  = mvalid_q && msg_ready;
   assign slot_free = !mvalid_q || msg_ready;

   always_comb begin
      grant = '0;
      for (int i = 0; i < LES_NUM_EVT; i++) begin
         if (slot_free && req[i] && (grant == '0)) begin
            grant[i] = 1'b1;
         end
      end
   end

   always_comb begin
      mvalid_d = mvalid_q;
      msg_d    = msg_q;
      if (accepted) begin
         mvalid_d = 1'b0;
      end
      for (int i = 0; i < LES_NUM_EVT; i++) begin
         if (grant[i]) begin
            mvalid_d = 1'b1;
            msg_d    = cmsg[i];
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         mvalid_q <= 1'b0;
         msg_q    <= '0;
      end else begin
         mvalid_q <= mvalid_d;
         msg_q    <= msg_d;
      end
   end

   assign msg_valid = mvalid_q;
   assign msg       = msg_q;

   // Register file: control, sticky status, clear, enable, live state
   always_comb begin
      evt_set                 = '0;
      evt_set[LES_IRQ_SENT]   = accepted;
      evt_set[LES_IRQ_RSVD]   = |rsvd_seen;
      evt_set[LES_IRQ_DROP]   = |dropped;

      ctrl_d  = ctrl_q;
      en_d    = en_q;
      stat_d  = stat_q;
      rdata_d = 32'h0000_0000;

      if (reg_wr && hit(reg_addr, LES_OFF_CTRL)) begin
         ctrl_d = reg_wdata & LES_CTRL_MASK;
      end
      if (reg_wr && hit(reg_addr, LES_OFF_EN)) begin
         en_d = reg_wdata[LES_IRQ_W-1:0];
      end
      if (reg_wr && hit(reg_addr, LES_OFF_CLR)) begin
         stat_d = stat_q & ~reg_wdata[LES_IRQ_W-1:0];
      end
      // A new event wins over a clear in the same cycle
      stat_d = stat_d | evt_set;

      if (reg_rd) begin
         case (reg_addr)
            LES_OFF_CTRL:  rdata_d = ctrl_q;
            LES_OFF_STAT:  rdata_d = {29'h0, stat_q};
            LES_OFF_EN:    rdata_d = {29'h0, en_q};
            LES_OFF_STATE: rdata_d = {25'h0, mvalid_q,
                                      event_status_register, asserted};
            default:       rdata_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ctrl_q  <= LES_CTRL_RST;
         en_q    <= LES_IRQ_RST;
         stat_q  <= LES_IRQ_RST;
         rdata_q <= 32'h0000_0000;
      end else begin
         ctrl_q  <= ctrl_d;
         en_q    <= en_d;
         stat_q  <= stat_d;
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata = rdata_q;
   assign irq       = |(stat_q & en_q);

   out_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
      msg_valid && !msg_ready |=> msg_valid && $stable(msg))
      else $error("Pending message changed before acceptance");

   grant_onehot_a: assert property (@(posedge clk_sys) disable iff (rst)
      $onehot0(grant) && (grant == '0 || slot_free))
      else $error("Arbiter granted more than one or a busy slot");

   sent_sticky_a: assert property (@(posedge clk_sys) disable iff (rst)
      accepted |=> stat_q[LES_IRQ_SENT] [*1])
      else $error("Accepted message did not set its status bit");

   rsvd_flag_a: assert property (@(posedge clk_sys) disable iff (rst)
      |rsvd_seen |=> stat_q[LES_IRQ_RSVD] ##1 1'b1)
      else $error("Reserved action not reported");

   irq_level_a: assert property (@(posedge clk_sys) disable iff (rst)
      reg_wr && hit(reg_addr, LES_OFF_EN) && reg_wdata[LES_IRQ_SENT]
      && accepted |=> ##[0:1] irq)
      else $error("Enabled event did not raise the interrupt");

   ctrl_mask_a: assert property (@(posedge clk_sys) disable iff (rst)
      (ctrl_q & ~LES_CTRL_MASK) == 32'h0000_0000)
      else $error("Bits outside the event fields were stored");

endmodule

// ==== les_host_model.sv ====
module les_host_model
   import les_pkg::*;
(
   // Clock and reset
   input  wire logic     clk_sys,
   input  wire logic     rst,
   // Message channel
   input  wire logic     msg_valid,
   input  wire les_msg_t msg,
   output logic          msg_ready,
   // Pacing and log
   input  wire logic     slow,
   output les_msg_t      last_msg,
   output int            n_got
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [1:0] wait_q;

   // Slow mode stalls every message for three cycles
   assign msg_ready = msg_valid && (!slow || wait_q == 2'h3);

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wait_q   <= 2'h0;
         n_got    <= 0;
         last_msg <= '0;
      end else if (msg_valid && msg_ready) begin
         wait_q   <= 2'h0;
         n_got    <= n_got + 1;
         last_msg <= msg;
      end else if (msg_valid) begin
         wait_q <= wait_q + 2'h1;
      end
   end
endmodule

// ==== tb.sv ====
module tb
   import les_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic                  clk_sys;
   logic                  rst;
   logic [LES_ADDR_W-1:0] reg_addr;
   logic [31:0]           reg_wdata;
   logic                  reg_wr;
   logic                  reg_rd;
   logic [31:0]           reg_rdata;
   logic [2:0]            evt;
   logic                  msi_en;
   logic                  intx_off;
   logic                  msg_valid;
   logic                  msg_ready;
   les_msg_t              msg;
   logic                  irq;
   logic                  slow;
   les_msg_t              last_msg;
   int                    n_got;
   int                    n_mismatch;
   int                    samples_checked;
   int                    seen;

   les_irq_select u_dut (
      .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .event_status_register(evt),
      .msg_irq_capability_en(msi_en), .legacy_irq_disable(intx_off),
      .msg_valid(msg_valid), .msg_ready(msg_ready), .msg(msg),
      .irq(irq));

   les_host_model u_host (
      .clk_sys(clk_sys), .rst(rst), .msg_valid(msg_valid), .msg(msg),
      .msg_ready(msg_ready), .slow(slow), .last_msg(last_msg),
      .n_got(n_got));

   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   task automatic give_verdict();
      $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk32(input logic [31:0] got, input logic [31:0] exp,
                        input string what);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic chkmsg(input les_msg_t got, input les_msg_t exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %0t message got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      #1;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                         input string what);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      chk32(reg_rdata, exp, what);
   endtask

   task automatic expect_msg(input les_msg_t exp);
      int k;
      k = 0;
      while (n_got == seen) begin
         @(posedge clk_sys);
         #1;
         k++;
         if (k > 50) begin
            n_mismatch++;
            $display("CHECK FAILED %0t message timeout", $time);
            give_verdict();
         end
      end
      seen++;
      chkmsg(last_msg, exp);
   endtask

   task automatic expect_none(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
      chk32(32'(n_got), 32'(seen), "unexpected message");
   endtask

   task automatic sc_regs();
      rd_chk(LES_OFF_CTRL, LES_CTRL_RST, "ctrl reset");
      rd_chk(LES_OFF_STAT, 32'h0, "status reset");
      rd_chk(LES_OFF_EN, 32'h0, "enable reset");
      wr(LES_OFF_CTRL, 32'hffff_ffff);
      rd_chk(LES_OFF_CTRL, 32'h0003_fe00, "ctrl fields");
      rd_chk(8'h14, 32'h0, "unmapped");
      wr(LES_OFF_CTRL, 32'h0);
   endtask

   task automatic sc_intx();
      les_msg_t em;
      for (int i = 0; i < 3; i++) begin
         for (int c = 2; c < 6; c++) begin
            // Field changes only while its status is clear
            wr(LES_OFF_CTRL, 32'(c) << (9 + 3 * i));
            @(posedge clk_sys);
            evt <= 3'(1 << i);
            em = '{LES_MSG_ASSERT, 2'(c - 2), 2'(i)};
            expect_msg(em);
            rd_chk(LES_OFF_STATE, 32'(9 << i), "state");
            @(posedge clk_sys);
            evt <= 3'h0;
            expect_msg('{LES_MSG_NEGATE, 2'(c - 2), 2'(i)});
         end
      end
   endtask

   task automatic sc_msi();
      @(posedge clk_sys);
      slow <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         wr(LES_OFF_CTRL, 32'h1 << (9 + 3 * i));
         @(posedge clk_sys);
         evt <= 3'(1 << i);
         expect_msg('{LES_MSG_MSI, 2'h0, 2'(i)});
         @(posedge clk_sys);
         evt <= 3'h0;
         expect_none(10);
      end
      wr(LES_OFF_CLR, 32'h7);
      @(posedge clk_sys);
      msi_en <= 1'b0;
      evt    <= 3'h4;
      expect_none(10);
      rd_chk(LES_OFF_STAT, 32'h4, "msi gated status");
      @(posedge clk_sys);
      evt  <= 3'h0;
      slow <= 1'b0;
      expect_none(4);
      @(posedge clk_sys);
      msi_en <= 1'b1;
   endtask

   task automatic sc_silent(input logic [2:0] c, input logic off,
                            input logic [31:0] st);
      wr(LES_OFF_CLR, 32'h7);
      wr(LES_OFF_CTRL, 32'(c) << 15);
      @(posedge clk_sys);
      intx_off <= off;
      evt      <= 3'h4;
      expect_none(10);
      rd_chk(LES_OFF_STAT, st, "silent status");
      @(posedge clk_sys);
      evt <= 3'h0;
      expect_none(10);
      @(posedge clk_sys);
      intx_off <= 1'b0;
   endtask

   task automatic sc_irq();
      wr(LES_OFF_CLR, 32'h7);
      wr(LES_OFF_STAT, 32'h7);
      rd_chk(LES_OFF_STAT, 32'h0, "status read only");
      rd_chk(LES_OFF_CLR, 32'h0, "clear reads zero");
      wr(LES_OFF_EN, 32'h1);
      rd_chk(LES_OFF_EN, 32'h1, "enable rw");
      wr(LES_OFF_CTRL, 32'h0000_0400);
      @(posedge clk_sys);
      evt <= 3'h1;
      expect_msg('{LES_MSG_ASSERT, 2'h0, 2'h0});
      chk32({31'h0, irq}, 32'h1, "irq raised");
      wr(LES_OFF_EN, 32'h0);
      chk32({31'h0, irq}, 32'h0, "irq masked");
      wr(LES_OFF_EN, 32'h1);
      chk32({31'h0, irq}, 32'h1, "irq unmasked");
      wr(LES_OFF_CLR, 32'h1);
      chk32({31'h0, irq}, 32'h0, "irq cleared");
      @(posedge clk_sys);
      evt <= 3'h0;
      expect_msg('{LES_MSG_NEGATE, 2'h0, 2'h0});
      wr(LES_OFF_CLR, 32'h7);
      wr(LES_OFF_EN, 32'h0);
   endtask

   initial begin
      rst             = 1'b1;
      reg_addr        = '0;
      reg_wdata       = '0;
      reg_wr          = 1'b0;
      reg_rd          = 1'b0;
      evt             = 3'h0;
      msi_en          = 1'b1;
      intx_off        = 1'b0;
      slow            = 1'b0;
      n_mismatch      = 0;
      samples_checked = 0;
      seen            = 0;
      repeat (8) @(posedge clk_sys);
      rst <= 1'b0;
      sc_regs();
      sc_intx();
      sc_msi();
      sc_silent(3'h0, 1'b0, 32'h0);
      sc_silent(3'h6, 1'b0, 32'h2);
      sc_silent(3'h7, 1'b0, 32'h2);
      sc_silent(3'h2, 1'b1, 32'h4);
      sc_irq();
      give_verdict();
   end
endmodule
